//--- dv/eic_pin_model.sv
/*
 * Far-side model: external interrupt sources driving the pins.
 * Assumes the bench sets wanted levels just after a rising edge.
 */
module eic_pin_model
    import eicfg_pkg::*;
(
    input wire logic clk,
    input wire logic [eicfg_pkg::NUM_CHAN-1:0] pinLevel,
    output logic [eicfg_pkg::NUM_CHAN-1:0] extPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // sources
    // registered, so no level can be shorter than one core clock
    always_ff @(posedge clk) begin
        extPin <= pinLevel;
    end
endmodule

//--- dv/test_external_interrupt_config.sv
/*
 * Self-checking bench for the external interrupt configuration block.
 * Assumes one AHB-Lite slave, so hready is fed from its hreadyout.
 */
module test_external_interrupt_config;
    timeunit 1ns;
    timeprecision 1ps;
    import eicfg_pkg::*;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wakeReq, irq;
    logic [31:0] hrdata;
    logic [8:0] pinLevel = 9'h000;
    logic [8:0] extPin, chanIrq;
    int errorCnt = 0;
    int cmpCount = 0;
    int cnt, ch;
    int modeExp [8] = '{1, 1, 2, 4, 8, 1, 2, 4};
    int chList [7] = '{0, 1, 2, 4, 5, 7, 8};

    eic_config DUT (.clk(clk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .extPin(extPin),
        .chanIrq(chanIrq), .wakeReq(wakeReq), .irq(irq));
    eic_pin_model pins (.clk(clk), .pinLevel(pinLevel), .extPin(extPin));

    // 40 MHz core clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // tasks
    task automatic end_sim();
        $display("errors %0d compares %0d", errorCnt, cmpCount);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait for hready at a rising edge; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            errorCnt++;
            end_sim();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a, exp);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        check(nm, v, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask
    // one pin high for four cycles; counts request cycles of that channel
    task automatic pulse_cnt(input int c, output int n);
        n = 0;
        repeat (4) @(posedge clk);
        pinLevel <= 9'h001 << c;
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            n += (chanIrq[c] === 1'b1);
            @(posedge clk);
            if (k == 3) begin
                pinLevel <= 9'h000;
            end
        end
    endtask
    // outputs are looked at mid-cycle, where they are settled
    task automatic irq_chk(input logic expIrq, expWake);
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, expIrq});
        check("wake", {31'h0, wakeReq}, {31'h0, expWake});
        @(posedge clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstN <= 1'b1;
        @(posedge clk);
        rd_chk("cfg_a", CFG_A_ADDR, 32'h0);
        rd_chk("cfg_b", CFG_B_ADDR, 32'h0);
        rd_chk("cfg_c", CFG_C_ADDR, 32'h0);
        rd_chk("clear", CLEAR_ADDR, 32'h0);
        // reserved fields must read zero; unmapped writes vanish
        wr(CFG_A_ADDR, 32'hFFFFFFFF);
        rd_chk("cfg_a", CFG_A_ADDR, 32'h00000FFF);
        wr(CFG_B_ADDR, 32'hFFFFFFFF);
        rd_chk("cfg_b", CFG_B_ADDR, 32'h0000F0FF);
        wr(CFG_C_ADDR, 32'hFFFFFFFF);
        rd_chk("cfg_c", CFG_C_ADDR, 32'h0000000F);
        wr(32'h4000242C, 32'hFFFFFFFF);
        rd_chk("unmapped", 32'h4000242C, 32'h0);
        // absent channels stay silent even with every field enabled
        pulse_cnt(3, cnt);
        check("chan3_cnt", 32'(cnt), 32'h0);
        pulse_cnt(6, cnt);
        check("chan6_cnt", 32'(cnt), 32'h0);
        // every detect code, aliases included, on channel 0
        for (int m = 0; m < 8; m++) begin
            wr(CFG_A_ADDR, 32'h8 | 32'(m));
            pulse_cnt(0, cnt);
            check("mode_cnt", 32'(cnt), 32'(modeExp[m]));
        end
        wr(CFG_A_ADDR, 32'h3);
        pulse_cnt(0, cnt);
        check("disabled_cnt", 32'(cnt), 32'h0);
        wr(CLEAR_ADDR, 32'hFFFF);
        rd_chk("status", STATUS_ADDR, 32'h0);
        // field position of each channel, high level mode
        for (int i = 0; i < 7; i++) begin
            ch = chList[i];
            wr(ch < 4 ? CFG_A_ADDR : ch < 8 ? CFG_B_ADDR : CFG_C_ADDR, 32'hB << (4 * (ch % 4)));
            pulse_cnt(ch, cnt);
            check("chan_cnt", 32'(cnt), 32'h4);
        end
        rd_chk("status", STATUS_ADDR, 32'h1B7);
        irq_chk(1'b0, 1'b1);
        wr(MASK_ADDR, 32'h1FF);
        rd_chk("mask", MASK_ADDR, 32'h1B7);
        irq_chk(1'b1, 1'b1);
        wr(CLEAR_ADDR, 32'h10);
        rd_chk("clear", CLEAR_ADDR, 32'h0);
        rd_chk("status", STATUS_ADDR, 32'h1A7);
        // flags also drop by writing one to the status word
        wr(STATUS_ADDR, 32'h1);
        rd_chk("status_w1c", STATUS_ADDR, 32'h1A6);
        wr(CLEAR_ADDR, 32'h1A6);
        rd_chk("status", STATUS_ADDR, 32'h0);
        irq_chk(1'b0, 1'b0);
        // a level still present re-sets its flag right through a clear
        wr(CFG_A_ADDR, 32'hB);
        pinLevel <= 9'h001;
        repeat (6) @(posedge clk);
        wr(CLEAR_ADDR, 32'h1);
        rd_chk("level_clear", STATUS_ADDR, 32'h1);
        irq_chk(1'b1, 1'b1);
        pinLevel <= 9'h000;
        repeat (6) @(posedge clk);
        wr(CLEAR_ADDR, 32'h1);
        rd_chk("level_gone", STATUS_ADDR, 32'h0);
        // a reset in mid-run returns every register to zero
        wr(CFG_B_ADDR, 32'hFFFF);
        rstN <= 1'b0;
        repeat (2) @(posedge clk);
        rstN <= 1'b1;
        @(posedge clk);
        rd_chk("cfg_b", CFG_B_ADDR, 32'h0);
        rd_chk("cfg_a", CFG_A_ADDR, 32'h0);
        rd_chk("cfg_c", CFG_C_ADDR, 32'h0);
        end_sim();
    end
endmodule

//--- hdl/eic_config.sv
/*
 * External interrupt configuration, detection and flag clearing.
 * Assumes one AHB-Lite master with this slave alone on the bus,
 * external pins asynchronous to clk, and clk always running.
 */
// Register access over AHB-Lite is this design's own decision.
module eic_config
    import eicfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [eicfg_pkg::NUM_CHAN-1:0] extPin,
    output logic [eicfg_pkg::NUM_CHAN-1:0] chanIrq,
    output logic wakeReq,
    output logic irq
);
    import eicfg_pkg::*;

    // folds the aliased codes onto the five real detect kinds
    function automatic eic_kind_type kindOf(input logic [2:0] sel);
        eic_kind_type k;
        k = EIC_RISE;
        unique case (sel)
            SEL_RISE: k = EIC_RISE;
            SEL_FALL, SEL_FALL_ALT: k = EIC_FALL;
            SEL_BOTH, SEL_BOTH_ALT: k = EIC_BOTH;
            SEL_HIGH, SEL_HIGH_ALT: k = EIC_HIGH;
            SEL_LOW: k = EIC_LOW;
        endcase
        return k;
    endfunction

    // ==================================================================
    // bus slave
    logic [31:0] addrQ;
    logic wrPend;
    logic rdPend;
    logic rdStage;
    logic [11:0] cfgA;
    logic [15:0] cfgB;
    logic [3:0] cfgC;
    logic [8:0] clearReg;
    logic [8:0] status;
    logic [8:0] mask;
    wire logic accept = hsel & htrans[1] & hready;
    wire logic wrNow = wrPend & hreadyout;
    wire logic wrCfgA = wrNow & (addrQ == CFG_A_ADDR);
    wire logic wrCfgB = wrNow & (addrQ == CFG_B_ADDR);
    wire logic wrCfgC = wrNow & (addrQ == CFG_C_ADDR);
    wire logic wrClear = wrNow & (addrQ == CLEAR_ADDR);
    wire logic wrStatus = wrNow & (addrQ == STATUS_ADDR);
    wire logic wrMask = wrNow & (addrQ == MASK_ADDR);
    wire logic [15:0] cfgARd = {4'h0, cfgA};
    wire logic [15:0] cfgBRd = {cfgB[15:12], 4'h0, cfgB[7:0]};
    wire logic [15:0] cfgCRd = {12'h000, cfgC};
    wire logic [15:0] clearRd = {7'h00, clearReg & CHAN_PRESENT};
    logic [15:0] readMux;

    // reads take one wait state so a read right after a write sees it
    assign hreadyout = ~(rdPend & ~rdStage);
    assign hresp = 1'b0;

    // unmapped addresses read as zero and ignore writes
    always_comb begin
        unique case (addrQ)
            CFG_A_ADDR: readMux = cfgARd;
            CFG_B_ADDR: readMux = cfgBRd;
            CFG_C_ADDR: readMux = cfgCRd;
            CLEAR_ADDR: readMux = clearRd;
            STATUS_ADDR: readMux = {7'h00, status};
            MASK_ADDR: readMux = {7'h00, mask};
            default: readMux = 16'h0000;
        endcase
    end

    // address phase capture and read data stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addrQ <= 32'h00000000;
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            rdStage <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            rdStage <= rdPend & ~rdStage;
            if (rdPend & ~rdStage) begin
                hrdata <= {16'h0000, readMux};
            end
            if (accept) begin
                addrQ <= haddr;
                wrPend <= hwrite;
                rdPend <= ~hwrite;
            end else if (hreadyout) begin
                wrPend <= 1'b0;
                rdPend <= 1'b0;
            end
        end
    end

    // ==================================================================
    // configuration and clear registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgA <= REG_RESET[11:0];
            cfgB <= REG_RESET;
            cfgC <= REG_RESET[3:0];
            clearReg <= REG_RESET[8:0];
            mask <= REG_RESET[8:0];
        end else begin
            if (wrCfgA) begin
                cfgA <= hwdata[11:0];
            end
            if (wrCfgB) begin
                cfgB <= {hwdata[15:12], 4'h0, hwdata[7:0]};
            end
            if (wrCfgC) begin
                cfgC <= hwdata[3:0];
            end
            // a clear bit lives for one cycle only, so software never writes 0
            clearReg <= wrClear ? (hwdata[8:0] & CHAN_PRESENT) : 9'h000;
            if (wrMask) begin
                mask <= hwdata[8:0] & CHAN_PRESENT;
            end
        end
    end

    // per-channel view of the packed fields; absent channels stay zero
    logic [3:0] chanCfg [NUM_CHAN];
    assign chanCfg[0] = cfgA[3:0];
    assign chanCfg[1] = cfgA[7:4];
    assign chanCfg[2] = cfgA[11:8];
    assign chanCfg[3] = 4'h0;
    assign chanCfg[4] = cfgB[3:0];
    assign chanCfg[5] = cfgB[7:4];
    assign chanCfg[6] = 4'h0;
    assign chanCfg[7] = cfgB[15:12];
    assign chanCfg[8] = cfgC;

    // ==================================================================
    // pin synchronisers and detection, on the always-on clock
    logic [8:0] syncA;
    logic [8:0] syncB;
    logic [8:0] prev;
    logic [8:0] event_;
    logic [8:0] next_chanIrq;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 9'h000;
            syncB <= 9'h000;
            prev <= 9'h000;
        end else begin
            syncA <= extPin;
            syncB <= syncA;
            prev <= syncB;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CHAN; i++) begin : g_chan
            eic_kind_type kind;
            logic rise;
            logic fall;
            logic hit;
            assign kind = kindOf(chanCfg[i][MODE_LSB +: 3]);
            assign rise = syncB[i] & ~prev[i];
            assign fall = ~syncB[i] & prev[i];
            // edges give a single-cycle hit, levels hit every cycle they last
            assign hit = ((kind == EIC_RISE) & rise) | ((kind == EIC_FALL) & fall)
                | ((kind == EIC_BOTH) & (rise | fall))
                | ((kind == EIC_HIGH) & syncB[i]) | ((kind == EIC_LOW) & ~syncB[i]);
            assign event_[i] = CHAN_PRESENT[i] & chanCfg[i][ENABLE_BIT] & hit;
        end
    endgenerate

    assign next_chanIrq = event_;

    // request lines to the core interrupt controller, plus sticky flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanIrq <= 9'h000;
            status <= 9'h000;
        end else begin
            chanIrq <= next_chanIrq;
            // a new event wins over a clear in the same cycle
            status <= event_ | (status & ~clearReg
                & ~(wrStatus ? hwdata[8:0] : 9'h000));
        end
    end

    // level outputs; the flags keep their state with no bus activity
    assign irq = |(status & mask);
    assign wakeReq = |status;

    // ==================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_rise_pulse: assert property (
        (chanCfg[0] == 4'h8) && syncB[0] && !prev[0] |=> chanIrq[0])
        else $error("rising edge on channel 0 not forwarded");
    chk_alias_fall: assert property (
        (chanCfg[0] == 4'hD) && !syncB[0] && prev[0] |=> chanIrq[0])
        else $error("alias falling code did not detect");
    chk_disable_quiet: assert property (
        !chanCfg[1][ENABLE_BIT] |=> !chanIrq[1])
        else $error("disabled channel raised a request");
    chk_clear_flag: assert property (
        clearReg[0] && !event_[0] |=> !status[0])
        else $error("clear did not drop channel 0 flag");
    chk_clear_self: assert property (
        (clearReg != 9'h000) && !wrClear |=> (clearReg == 9'h000))
        else $error("clear register did not self-clear");
    chk_reserved_zero: assert property (
        (cfgCRd[15:4] == 12'h000) && (cfgBRd[11:8] == 4'h0) && !clearRd[3] && !clearRd[6])
        else $error("reserved bits read nonzero");
    chk_level_hold: assert property (
        (chanCfg[8] == 4'hB) && syncB[8] [*2] |-> ##1 chanIrq[8] && $past(chanIrq[8]))
        else $error("high level request not held");
    chk_flag_sticky: assert property (
        status[2] && !clearReg[2] && !wrStatus |=> status[2])
        else $error("flag lost without a clear");
    chk_sync_delay: assert property (
        (chanCfg[4] == 4'hB) && $rose(syncB[4]) |-> $past(extPin[4], 2) ##1 chanIrq[4])
        else $error("level not seen through synchroniser");
    chk_read_wait: assert property (
        rdPend && !rdStage |-> !hreadyout ##1 hreadyout)
        else $error("read wait state missing");
    chk_write_nowait: assert property (
        wrPend |-> hreadyout)
        else $error("write data phase stretched");

    // remaining detect kinds on channel 0, where every code gets walked, then high level on channels 2, 5 and 7
    chk_both_edge: assert property (
        (chanCfg[0] == 4'hA) && (syncB[0] != prev[0]) |=> chanIrq[0])
        else $error("either-edge code missed a transition");
    chk_fall_ignores: assert property (
        (chanCfg[0] == 4'h9) && syncB[0] && !prev[0] |=> !chanIrq[0])
        else $error("falling code reacted to a rising edge");
    chk_low_level: assert property (
        (chanCfg[0] == 4'hC) && !syncB[0] |=> chanIrq[0])
        else $error("low level on channel 0 not forwarded");
    chk_alias_both: assert property (
        (chanCfg[0] == 4'hE) && (syncB[0] != prev[0]) |=> chanIrq[0])
        else $error("alias either-edge code missed a transition");
    chk_alias_high: assert property (
        (chanCfg[0] == 4'hF) && syncB[0] |=> chanIrq[0])
        else $error("alias high code did not detect");
    // the mode must have stood a cycle, or a level left over from before looks like an edge
    chk_edge_single: assert property (
        (chanCfg[0] == 4'h8) && ($past(chanCfg[0]) == 4'h8) && chanIrq[0] |=> !chanIrq[0])
        else $error("edge request lasted more than one cycle");
    chk_high_ch2: assert property (
        (chanCfg[2] == 4'hB) && syncB[2] |=> chanIrq[2])
        else $error("high level on channel 2 not forwarded");
    chk_high_ch5: assert property (
        (chanCfg[5] == 4'hB) && syncB[5] |=> chanIrq[5])
        else $error("high level on channel 5 not forwarded");
    chk_high_ch7: assert property (
        (chanCfg[7] == 4'hB) && syncB[7] |=> chanIrq[7])
        else $error("high level on channel 7 not forwarded");

    // flags, clear bits and reset state
    chk_enable_gate: assert property (
        !chanCfg[8][ENABLE_BIT] && !status[8] |=> !status[8])
        else $error("disabled channel set its flag");
    chk_event_wins: assert property (
        event_[0] |=> status[0])
        else $error("event lost against a clear in the same cycle");
    chk_clear_position: assert property (
        wrClear && hwdata[4] |=> clearReg[4])
        else $error("clear bit not at its channel position");
    chk_absent_quiet: assert property (
        !chanIrq[3] && !chanIrq[6] && !status[3] && !status[6])
        else $error("absent channel became active");
    chk_reset_values: assert property (
        $rose(rst_n) |-> (cfgA == REG_RESET[11:0]) && (cfgB == REG_RESET)
            && (cfgC == REG_RESET[3:0]) && (clearReg == REG_RESET[8:0]))
        else $error("register not at reset value after reset");
    chk_wake_flag: assert property (
        (status != 9'h000) |-> wakeReq)
        else $error("pending flag without wake request");
    chk_irq_masked: assert property (
        ((status & mask) == 9'h000) |-> !irq)
        else $error("interrupt raised with every flag masked");
endmodule

//--- hdl/eicfg_pkg.sv
/*
 * Constants shared by the external interrupt configuration block:
 * register addresses, field layout, reset values and detect kinds.
 * Assumes a 32-bit AHB-Lite bus with word-aligned register accesses.
 */
package eicfg_pkg;
    // ==================================================================
    // register byte addresses
    localparam logic [31:0] CFG_A_ADDR = 32'h40002420;
    localparam logic [31:0] CFG_B_ADDR = 32'h40002424;
    localparam logic [31:0] CFG_C_ADDR = 32'h40002428;
    localparam logic [31:0] CLEAR_ADDR = 32'h40002430;
    localparam logic [31:0] STATUS_ADDR = 32'h40002434;
    localparam logic [31:0] MASK_ADDR = 32'h40002438;

    // ==================================================================
    // reset values and channel layout
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int NUM_CHAN = 9;
    localparam logic [8:0] CHAN_PRESENT = 9'h1B7;
    localparam int MODE_LSB = 0;
    localparam int ENABLE_BIT = 3;
    localparam int FIELD_W = 4;

    // ==================================================================
    // detect kinds after alias folding
    typedef enum logic [2:0] {
        EIC_RISE = 3'b000,
        EIC_FALL = 3'b001,
        EIC_BOTH = 3'b010,
        EIC_HIGH = 3'b011,
        EIC_LOW = 3'b100
    } eic_kind_type;

    // ==================================================================
    // detect-select codes
    localparam logic [2:0] SEL_RISE = 3'b000;
    localparam logic [2:0] SEL_FALL = 3'b001;
    localparam logic [2:0] SEL_BOTH = 3'b010;
    localparam logic [2:0] SEL_HIGH = 3'b011;
    localparam logic [2:0] SEL_LOW = 3'b100;
    localparam logic [2:0] SEL_FALL_ALT = 3'b101;
    localparam logic [2:0] SEL_BOTH_ALT = 3'b110;
    localparam logic [2:0] SEL_HIGH_ALT = 3'b111;
endpackage
